// file: fog_pkg.sv
package fog_pkg;
    // ******************************
    // Register map
    // ******************************
    localparam logic [7:0] OFS_OVL_CTRL = 8'h00;  // ram_overlay_control
    localparam logic [7:0] OFS_ERR_STAT = 8'h04;  // flash_error_status
    localparam logic [7:0] OFS_MODE_STAT = 8'h08; // Mode and pin state
    // Reset and fixed-one patterns
    localparam logic [7:0] OVL_CTRL_RST = 8'hf1;
    localparam logic [7:0] OVL_FIXED_ONES = 8'hf1;
    localparam logic [7:0] ERR_FIXED_ONES = 8'h7f;
    // Field positions
    localparam int OVL_EN_BIT = 3;
    localparam int OVL_SEL_HI_BIT = 2;
    localparam int OVL_SEL_LO_BIT = 1;
    localparam int ERR_FLAG_BIT = 7;
    // Address windows
    localparam logic [23:0] RAM_WIN_BASE = 24'hfff800;
    localparam logic [23:0] FLASH_OVL_BASE = 24'h000000;
    localparam int WIN_BITS = 10;
    localparam logic [23:0] FLASH_TOP = 24'h020000;
    // Mode numbers
    localparam logic [2:0] MODE_FIVE = 3'h5;
    localparam logic [2:0] MODE_SIX = 3'h6;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin group sampled from outside
    typedef struct packed {
        logic write_enable_pin;
        logic mode_pin_two;
        logic mode_pin_one;
        logic mode_pin_zero;
    } fog_pins_s;

    // Decoded operating mode
    typedef struct packed {
        logic [2:0] mode;
        logic boot;
        logic user;
    } fog_mode_s;
endpackage : fog_pkg

// file: fog_top.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Function
// - Overlay bits 7..4 and 0 read one
// - Select bits zero outside modes 5-7
// - Select bits writable in modes 5-7
// - Select bits cleared by reset, hardware standby
// - Overlay enable blocks program and erase
// - Select bits pick remapped 1 KB range
// - Flash read during operation sets error
// - Qualifying exception during operation sets error
// - Sleep during operation sets error
// - Error flag refuses program and erase
// - Error cleared only by resets, standby
// - Status bits 6..0 read one
// - Pins decode boot and user modes
// - Boot mode inverts highest mode pin
// - Mode 6 has no on-board programming
// - Mode monitor reports 5 or 7 in boot mode
// - Write-enable status follows its pin
module fog_top (
    input wire logic clk,                  // 20 MHz system clock
    input wire logic rst,                  // Reset pin, synchronous, high
    input wire logic wdt_reset,            // Watchdog reset pulse
    input wire logic hw_standby,           // Hardware standby level
    input wire fog_pkg::fog_pins_s pins,   // Raw mode and write-enable pins
    input wire logic pe_active,            // Program or erase under way
    input wire logic exc_seq,              // Qualifying exception sequence start
    input wire logic sleep_exec,           // Sleep instruction executed
    input wire logic cpu_valid,            // CPU access strobe
    input wire logic cpu_read,             // CPU access is a read or fetch
    input wire logic [23:0] cpu_addr,      // CPU byte address
    output logic ram_sel,                  // Access goes to on-chip RAM
    output logic [9:0] ram_offset,         // Offset inside the 1 KB RAM window
    output logic flash_sel,                // Access goes to the flash array
    output logic pe_allowed,               // Program and erase permitted
    output logic program_error_flag,       // Sticky error flag
    output logic write_enable_status,      // Synchronised write-enable pin
    output fog_pkg::fog_mode_s mode_monitor, // Decoded mode
    input wire logic [7:0] awaddr,         // AXI write address
    input wire logic awvalid,              // AXI write address valid
    output logic awready,                  // AXI write address ready
    input wire logic [31:0] wdata,         // AXI write data
    input wire logic [3:0] wstrb,          // AXI byte strobes
    input wire logic wvalid,               // AXI write data valid
    output logic wready,                   // AXI write data ready
    output logic [1:0] bresp,              // AXI write response
    output logic bvalid,                   // AXI write response valid
    input wire logic bready,               // AXI write response ready
    input wire logic [7:0] araddr,         // AXI read address
    input wire logic arvalid,              // AXI read address valid
    output logic arready,                  // AXI read address ready
    output logic [31:0] rdata,             // AXI read data
    output logic [1:0] rresp,              // AXI read response
    output logic rvalid,                   // AXI read data valid
    input wire logic rready                // AXI read data ready
);
    // ******************************
    // Pin synchronisers
    // ******************************
    fog_pkg::fog_pins_s pin_meta; // First stage, read only by second
    fog_pkg::fog_pins_s pin_sync; // Second stage, safe to use
    fog_pkg::fog_mode_s next_mode; // Decoded mode from pins
    logic [2:0] pin_num;           // Raw pin mode number

    // Two flops before any decode
    always_ff @(posedge clk) begin
        pin_meta <= pins;
        pin_sync <= pin_meta;
    end

    // ******************************
    // Mode decode
    // ******************************
    assign pin_num = {pin_sync.mode_pin_two, pin_sync.mode_pin_one, pin_sync.mode_pin_zero};
    // boot when enabled, low pin two, high pin zero
    assign next_mode.boot = pin_sync.write_enable_pin & ~pin_sync.mode_pin_two
                            & pin_sync.mode_pin_zero;
    // boot reports mode 5 or 7
    assign next_mode.mode = next_mode.boot ? {1'b1, pin_num[1:0]} : pin_num;
    // mode 6 never on-board: pin zero low excludes it
    assign next_mode.user = pin_sync.write_enable_pin & pin_sync.mode_pin_two
                            & pin_sync.mode_pin_zero;

    logic mode_ok;   // Flash-enabled modes 5 to 7
    assign mode_ok = mode_monitor.mode >= fog_pkg::MODE_FIVE;

    // Mode monitor and write-enable status registered
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_monitor <= '0;
            write_enable_status <= 1'b0;
        end else begin
            mode_monitor <= next_mode;
            write_enable_status <= pin_sync.write_enable_pin;
        end
    end

    // ******************************
    // Overlay decode
    // ******************************
    logic [2:0] ovl_bits;   // Enable, select high, select low
    logic ovl_en;           // Effective overlay enable
    logic [1:0] ovl_sel;    // Range select
    logic in_ram_win;       // Address in the normal RAM window
    logic in_ovl_range;     // Address in the selected flash range
    logic in_flash;         // Address in flash space
    logic ovl_hit;          // Flash address remapped to RAM

    // outside modes 5-7 the bits act as zero
    assign ovl_en = ovl_bits[2] & mode_ok;
    assign ovl_sel = ovl_bits[1:0];
    assign in_ram_win = cpu_addr[23:fog_pkg::WIN_BITS]
        == fog_pkg::RAM_WIN_BASE[23:fog_pkg::WIN_BITS];
    // select picks one of four 1 KB ranges
    assign in_ovl_range = cpu_addr[23:fog_pkg::WIN_BITS]
        == (fog_pkg::FLASH_OVL_BASE[23:fog_pkg::WIN_BITS] + {12'h000, ovl_sel});
    assign in_flash = cpu_addr < fog_pkg::FLASH_TOP;
    assign ovl_hit = ovl_en & in_ovl_range;

    // Routing registered; decode uses current bits, so the next access remaps
    always_ff @(posedge clk) begin
        if (rst) begin
            ram_sel <= 1'b0;
            flash_sel <= 1'b0;
            ram_offset <= '0;
        end else begin
            ram_sel <= cpu_valid & (in_ram_win | ovl_hit);
            flash_sel <= cpu_valid & in_flash & ~ovl_hit;
            ram_offset <= cpu_addr[fog_pkg::WIN_BITS-1:0];
        end
    end

    // ******************************
    // Error flag and protection
    // ******************************
    logic err_event;   // Any setting condition this cycle
    logic err_clear;   // Any clearing condition
    assign err_event = pe_active & ((cpu_valid & cpu_read & in_flash & ~ovl_hit)
                       | exc_seq | sleep_exec);
    assign err_clear = rst | wdt_reset | hw_standby;

    // Resets and hardware standby dominate: nothing else may clear the flag
    always_ff @(posedge clk) begin
        if (err_clear) begin
            program_error_flag <= 1'b0;
        end else if (err_event) begin
            program_error_flag <= 1'b1;
        end
    end

    // Permission needs pin, on-board mode, no overlay, no error
    always_ff @(posedge clk) begin
        if (rst) begin
            pe_allowed <= 1'b0;
        end else begin
            pe_allowed <= pin_sync.write_enable_pin & (mode_monitor.boot | mode_monitor.user)
                          & ~ovl_en & ~program_error_flag;
        end
    end

    // ******************************
    // AXI4-Lite slave
    // ******************************
    logic aw_full;        // Write address held
    logic w_full;         // Write data held
    logic [7:0] aw_q;     // Held write address
    logic [7:0] wd_q;     // Held low data byte
    logic ws_q;           // Held low-lane strobe
    logic do_write;       // Both halves present
    logic wr_ovl;         // Write hits overlay control
    logic wr_ok;          // Write address mapped
    logic [7:0] ovl_rd;   // Overlay control read view
    logic [7:0] err_rd;   // Status read view
    logic [31:0] rd_mux;  // Selected read word
    logic rd_ok;          // Read address mapped

    assign do_write = aw_full & w_full & ~bvalid;
    assign wr_ovl = aw_q == fog_pkg::OFS_OVL_CTRL;
    assign wr_ok = wr_ovl | (aw_q == fog_pkg::OFS_ERR_STAT) | (aw_q == fog_pkg::OFS_MODE_STAT);
    assign ovl_rd = fog_pkg::OVL_FIXED_ONES | {4'h0, mode_ok ? ovl_bits : 3'h0, 1'b0};
    assign err_rd = fog_pkg::ERR_FIXED_ONES | {program_error_flag, 7'h00};
    assign rd_ok = (araddr == fog_pkg::OFS_OVL_CTRL) | (araddr == fog_pkg::OFS_ERR_STAT)
                   | (araddr == fog_pkg::OFS_MODE_STAT);
    assign rd_mux = (araddr == fog_pkg::OFS_OVL_CTRL) ? {24'h000000, ovl_rd}
                  : (araddr == fog_pkg::OFS_ERR_STAT) ? {24'h000000, err_rd}
                  : (araddr == fog_pkg::OFS_MODE_STAT) ? {26'h0000000, write_enable_status,
                     mode_monitor} : 32'h00000000;

    // Write channels: one write in flight, ready drops until response taken
    always_ff @(posedge clk) begin
        if (rst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_q <= '0;
            wd_q <= '0;
            ws_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= fog_pkg::RESP_OKAY;
        end else begin
            // Address and data taken in either order
            if (awvalid & awready) begin
                aw_full <= 1'b1;
                aw_q <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid & wready) begin
                w_full <= 1'b1;
                wd_q <= wdata[7:0];
                ws_q <= wstrb[0];
                wready <= 1'b0;
            end
            // Response once both halves held
            if (do_write) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? fog_pkg::RESP_OKAY : fog_pkg::RESP_SLVERR;
            end
            if (bvalid & bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Overlay bits: survive software standby, lost on reset or hardware standby
    always_ff @(posedge clk) begin
        if (rst | hw_standby) begin
            ovl_bits <= fog_pkg::OVL_CTRL_RST[3:1];
        end else if (do_write & wr_ovl & ws_q & mode_ok) begin
            ovl_bits <= wd_q[3:1];
        end
    end

    // Read channel: answer one cycle after address taken
    always_ff @(posedge clk) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= fog_pkg::RESP_OKAY;
        end else if (arvalid & arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_ok ? fog_pkg::RESP_OKAY : fog_pkg::RESP_SLVERR;
        end else if (rvalid & rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ******************************
    // Assertions
    // ******************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic rd_was_ovl; // Last read targeted overlay control
    always_ff @(posedge clk) begin
        if (arvalid & arready) begin
            rd_was_ovl <= araddr == fog_pkg::OFS_OVL_CTRL;
        end
    end

    reserved_ones_a: assert property (rvalid & rd_was_ovl |->
        rdata[7:4] == 4'hf && rdata[0])
        else $error("overlay reserved bits not one");
    sel_outside_a: assert property (!mode_ok |=> !ram_sel || $past(in_ram_win))
        else $error("remap outside flash modes");
    sel_write_a: assert property (do_write & wr_ovl & ws_q & mode_ok & !hw_standby
        |=> ovl_bits == $past(wd_q[3:1]))
        else $error("overlay write lost");
    standby_clear_a: assert property (hw_standby |=>
        ovl_bits == 3'h0 && !program_error_flag)
        else $error("standby did not clear");
    overlay_protect_a: assert property (ovl_en |=> !pe_allowed)
        else $error("operation allowed under overlay");
    error_set_a: assert property (err_event & !wdt_reset & !hw_standby
        |=> program_error_flag [*2] or (program_error_flag ##1 !program_error_flag))
        else $error("error flag not set");
    error_hold_a: assert property (program_error_flag & !wdt_reset & !hw_standby
        |=> program_error_flag)
        else $error("error flag dropped");
    error_protect_a: assert property (program_error_flag |=> !pe_allowed)
        else $error("operation allowed under error");
    mode_six_a: assert property (mode_monitor.mode == fog_pkg::MODE_SIX
        |-> !mode_monitor.boot && !mode_monitor.user)
        else $error("on-board mode in mode 6");
    // Starts only out of reset, so the cleared status at release is not flagged
    wen_follow_a: assert property (!rst |=>
        write_enable_status == $past(pin_sync.write_enable_pin))
        else $error("write-enable status stale");

    remap_cov: cover property (ovl_en ##1 ram_sel);
    error_cov: cover property (!program_error_flag ##1 program_error_flag);
    boot_cov: cover property (mode_monitor.boot ##1 pe_allowed);
endmodule : fog_top

// file: fog_cpu_model.sv
`timescale 1ns/1ps
// CPU and flash-side partner: bus fetches, program/erase level, CPU events
module fog_cpu_model (
    input wire logic clk,        // System clock
    output logic cpu_valid,      // Access strobe
    output logic cpu_read,       // Read or fetch
    output logic [23:0] cpu_addr, // Byte address
    output logic pe_active,      // Program or erase running
    output logic exc_seq,        // Exception sequence pulse
    output logic sleep_exec      // Sleep instruction pulse
);
    initial begin
        cpu_valid = 1'b0;
        cpu_read = 1'b0;
        cpu_addr = 24'h000000;
        pe_active = 1'b0;
        exc_seq = 1'b0;
        sleep_exec = 1'b0;
    end
    // One read cycle; the idle address is inverted so stale values never look valid
    task automatic access(input logic [23:0] a);
        @(posedge clk);
        cpu_valid <= 1'b1;
        cpu_read <= 1'b1;
        cpu_addr <= a;
        @(posedge clk);
        cpu_valid <= 1'b0;
        cpu_read <= 1'b0;
        cpu_addr <= ~a;
    endtask : access
    // Program or erase level as the flash sequencer would show it
    task automatic set_pe(input logic b);
        @(posedge clk);
        pe_active <= b;
    endtask : set_pe
    // One-cycle event: sleep when s is high, qualifying exception otherwise
    task automatic evt(input logic s);
        @(posedge clk);
        if (s) begin
            sleep_exec <= 1'b1;
        end else begin
            exc_seq <= 1'b1;
        end
        @(posedge clk);
        sleep_exec <= 1'b0;
        exc_seq <= 1'b0;
    endtask : evt
endmodule : fog_cpu_model

// file: flash_overlay_and_error_guard_tb_top.sv
`timescale 1ns/1ps
module flash_overlay_and_error_guard_tb_top;
    logic clk = 1'b0, rst = 1'b1, wdt_reset = 1'b0, hw_standby = 1'b0; // Clock and clears
    fog_pkg::fog_pins_s pins = 4'hf;       // Mode and write-enable pins
    logic cpu_valid, cpu_read, pe_active, exc_seq, sleep_exec; // From partner
    logic [23:0] cpu_addr;                 // From partner
    logic ram_sel, flash_sel, pe_allowed, program_error_flag, write_enable_status;
    logic [9:0] ram_offset;                // RAM window offset
    fog_pkg::fog_mode_s mode_monitor;      // Decoded mode
    logic [7:0] awaddr = 8'h00, araddr = 8'h00; // Bus addresses
    logic [31:0] wdata = 32'h0, rdata;     // Bus data
    logic [3:0] wstrb = 4'hf;              // Byte strobes
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid; // Slave handshakes
    logic [1:0] bresp, rresp, r;           // Responses
    int errors = 0, n_tests = 0, i, s;     // Tally and loop indices
    logic [3:0] tp[7] = '{4'hf, 4'hd, 4'hb, 4'h9, 4'he, 4'h4, 4'h5}; // Pin settings
    logic [7:0] tm[7] = '{8'h3d, 8'h35, 8'h3e, 8'h36, 8'h38, 8'h10, 8'h14}; // Mode word
    logic [7:0] tov[7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hf1, 8'hf1, 8'hff}; // Overlay
    logic tpe[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0}; // Program permitted
    fog_cpu_model cpu (.clk(clk), .cpu_valid(cpu_valid), .cpu_read(cpu_read),
        .cpu_addr(cpu_addr), .pe_active(pe_active), .exc_seq(exc_seq), .sleep_exec(sleep_exec));
    fog_top DUT (.clk(clk), .rst(rst), .wdt_reset(wdt_reset), .hw_standby(hw_standby),
        .pins(pins), .pe_active(pe_active), .exc_seq(exc_seq), .sleep_exec(sleep_exec),
        .cpu_valid(cpu_valid), .cpu_read(cpu_read), .cpu_addr(cpu_addr), .ram_sel(ram_sel),
        .ram_offset(ram_offset), .flash_sel(flash_sel), .pe_allowed(pe_allowed),
        .program_error_flag(program_error_flag), .write_enable_status(write_enable_status),
        .mode_monitor(mode_monitor), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    initial begin
        forever #25 clk = ~clk;
    end
    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic tally_and_finish;
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    // Pin changes are followed by a full reset so the synchronisers are flushed
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset
    // Address and data offered together; bready held until the response edge
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a;
        // Upper lanes carry copies so that their being ignored is exercised
        wdata <= {d, d, d, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        errors++;
        tally_and_finish();
    endtask : axi_wr
    // Read and compare data and response at the edge where rvalid is seen
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                chk_val(rdata, exp);
                chk_val({30'h0, rresp}, {30'h0, er});
                rready <= 1'b0;
                return;
            end
        end
        errors++;
        tally_and_finish();
    endtask : rd_chk
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        // Seven pin settings, then overlay writability; mode 6 only ever gets zero
        for (i = 0; i < 7; i++) begin
            pins <= tp[i];
            do_reset();
            rd_chk(fog_pkg::OFS_MODE_STAT, {24'h0, tm[i]}, fog_pkg::RESP_OKAY);
            chk_bit(pe_allowed, tpe[i]);
            rd_chk(fog_pkg::OFS_ERR_STAT, 32'h7f, fog_pkg::RESP_OKAY);
            axi_wr(fog_pkg::OFS_OVL_CTRL, (tp[i] == 4'he) ? 8'h00 : 8'h0e);
            chk_val({30'h0, r}, {30'h0, fog_pkg::RESP_OKAY});
            rd_chk(fog_pkg::OFS_OVL_CTRL, {24'h0, tov[i]}, fog_pkg::RESP_OKAY);
        end
        pins <= 4'hf;
        do_reset();
        // Software has enabled the on-chip RAM before any overlay is used
        // memory enabled
        for (s = 0; s < 4; s++) begin
            axi_wr(fog_pkg::OFS_OVL_CTRL, {4'hf, 1'b1, s[1:0], 1'b1});
            rd_chk(fog_pkg::OFS_OVL_CTRL, {24'h0, 4'hf, 1'b1, s[1:0], 1'b1}, 2'h0);
            cpu.access({12'h0, s[1:0], 10'h123});
            #1 chk_val({ram_sel, flash_sel, ram_offset}, {2'b10, 10'h123});
            chk_bit(pe_allowed, 1'b0);
            cpu.access({12'h0, s[1:0] + 2'd1, 10'h000});
            #1 chk_val({ram_sel, flash_sel}, 32'h1);
        end
        // Lane 0 strobe low: the overlay write must be dropped
        @(posedge clk);
        wstrb <= 4'he;
        axi_wr(fog_pkg::OFS_OVL_CTRL, 8'h02);
        wstrb <= 4'hf;
        rd_chk(fog_pkg::OFS_OVL_CTRL, 32'hff, fog_pkg::RESP_OKAY);
        axi_wr(fog_pkg::OFS_OVL_CTRL, 8'h02);
        cpu.access(24'h000523);
        #1 chk_val({ram_sel, flash_sel}, 32'h1);
        chk_bit(pe_allowed, 1'b1);
        cpu.access(24'hfff9ab);
        #1 chk_val({ram_sel, ram_offset}, {1'b1, 10'h1ab});
        axi_wr(8'h0c, 8'h0e);
        chk_val({30'h0, r}, {30'h0, fog_pkg::RESP_SLVERR});
        rd_chk(8'h0c, 32'h0, fog_pkg::RESP_SLVERR);
        // Error flag: overlaid reads are harmless, flash reads and events are not
        axi_wr(fog_pkg::OFS_OVL_CTRL, 8'h08);
        cpu.set_pe(1'b1);
        cpu.access(24'h000010);
        repeat (2) @(posedge clk);
        chk_bit(program_error_flag, 1'b0);
        axi_wr(fog_pkg::OFS_OVL_CTRL, 8'h00);
        cpu.access(24'h001000);
        repeat (2) @(posedge clk);
        rd_chk(fog_pkg::OFS_ERR_STAT, 32'hff, fog_pkg::RESP_OKAY);
        chk_bit(pe_allowed, 1'b0);
        wdt_reset <= 1'b1;
        @(posedge clk);
        wdt_reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk_bit(program_error_flag, 1'b0);
        axi_wr(fog_pkg::OFS_OVL_CTRL, 8'h0e);
        cpu.evt(1'b0);
        repeat (2) @(posedge clk);
        chk_bit(program_error_flag, 1'b1);
        hw_standby <= 1'b1;
        repeat (2) @(posedge clk);
        hw_standby <= 1'b0;
        repeat (2) @(posedge clk);
        chk_bit(program_error_flag, 1'b0);
        rd_chk(fog_pkg::OFS_OVL_CTRL, 32'hf1, fog_pkg::RESP_OKAY);
        cpu.evt(1'b1);
        repeat (2) @(posedge clk);
        chk_bit(program_error_flag, 1'b1);
        cpu.set_pe(1'b0);
        do_reset();
        // Events with no operation running leave the flag alone
        cpu.evt(1'b1);
        cpu.access(24'h001000);
        @(posedge clk);
        chk_bit(program_error_flag, 1'b0);
        tally_and_finish();
    end
endmodule : flash_overlay_and_error_guard_tb_top
